// ===== design/jpdn_pkg.sv
// constants for the jack pin node and the output converter node
// assumes verbs arrive already deframed from the link, one per strobe
package jpdn_pkg;

  // node addresses
  localparam logic [7:0]  NODE_JACK        = 8'h0f;
  localparam logic [7:0]  NODE_DAC         = 8'h10;
  localparam logic [6:0]  NODE_SOURCE      = 7'h11;

  // twelve bit verbs
  localparam logic [11:0] VRB_GET_PARAM    = 12'hf00;
  localparam logic [11:0] VRB_GET_SRC_LIST = 12'hf02;
  localparam logic [11:0] VRB_GET_POWER    = 12'hf05;
  localparam logic [11:0] VRB_SET_POWER    = 12'h705;
  localparam logic [11:0] VRB_GET_PIN_CTL  = 12'hf07;
  localparam logic [11:0] VRB_SET_PIN_CTL  = 12'h707;
  localparam logic [11:0] VRB_GET_EVT_CTL  = 12'hf08;
  localparam logic [11:0] VRB_SET_EVT_CTL  = 12'h708;
  localparam logic [11:0] VRB_GET_SENSE    = 12'hf09;
  localparam logic [11:0] VRB_SET_SENSE    = 12'h709;
  localparam logic [11:0] VRB_GET_CONFIG   = 12'hf1c;
  localparam logic [11:0] VRB_SET_CONFIG0  = 12'h71c;
  localparam logic [11:0] VRB_SET_CONFIG1  = 12'h71d;
  localparam logic [11:0] VRB_SET_CONFIG2  = 12'h71e;
  localparam logic [11:0] VRB_SET_CONFIG3  = 12'h71f;
  localparam logic [11:0] VRB_GET_AMP_R    = 12'hb80;
  localparam logic [11:0] VRB_SET_AMP_R    = 12'h390;
  localparam logic [11:0] VRB_GET_AMP_L    = 12'hba0;
  localparam logic [11:0] VRB_SET_AMP_L    = 12'h3a0;

  // four bit verbs with sixteen bit payload
  localparam logic [3:0]  VRB4_SET_FORMAT  = 4'h2;
  localparam logic [3:0]  VRB4_GET_FORMAT  = 4'ha;

  // parameter ids for the parameter read
  localparam logic [7:0]  PAR_NODE_CAPS    = 8'h09;
  localparam logic [7:0]  PAR_PIN_CAPS     = 8'h0c;
  localparam logic [7:0]  PAR_LIST_LEN     = 8'h0e;

  // field positions
  localparam int          PC_OUT_BIT       = 4;
  localparam int          WC_LIST_BIT      = 8;
  localparam int          CTL_OUT_BIT      = 6;
  localparam int          CTL_IN_BIT       = 5;
  localparam int          EVT_EN_BIT       = 7;
  localparam int          TAG_LSB          = 26;

  // fixed capability words
  localparam logic [7:0]  BIAS_SUPPORT     = 8'h17;
  localparam logic [31:0] PIN_CAPS_BASE    = 32'h0000_1727;
  localparam logic [31:0] PIN_NODE_CAPS    = 32'h0040_0081;
  localparam logic [31:0] DAC_NODE_CAPS    = 32'h000d_0c05;

  // reset values, power down code and format write mask
  localparam logic [31:0] CONFIG_RST       = 32'h01a1_9040;
  localparam logic [15:0] FORMAT_RST       = 16'h0031;
  localparam logic [7:0]  AMP_RST          = 8'hff;
  localparam logic [1:0]  POWER_RST        = 2'h3;
  localparam logic [1:0]  POWER_DOWN       = 2'h3;
  localparam logic [30:0] IMP_UNKNOWN      = 31'h7fff_ffff;
  localparam logic [15:0] FORMAT_RW_MASK   = 16'h7f7f;

  // sample rate terms
  localparam int          RATE_48K_HZ      = 48000;
  localparam int          RATE_44K1_HZ     = 44100;
  localparam int          RATE_W           = 18;

endpackage : jpdn_pkg

// ===== design/jpdn_nodes.sv
// verb handling for the microphone jack node and the output converter node
// assumes link_clk runs free whenever the link is up; verbs arrive deframed
// on link_clk, the impedance measurement front end sits on clock
//
// Notes on behaviour
// - pin caps: bias 0x17, input, sense, trigger
// - pin output flag follows second converter
// - list length short form, one or zero
// - list entry 0x11 only when converter on
// - pin control output and input enables
// - unsupported bias codes stored as hi-z
// - twelve bit sets use low byte, answer zero
// - event report on insertion or sense done
// - software tag in event bits 31:26
// - sense read: presence and impedance, ones busy
// - sense write starts measurement, bit0 side
// - config word bytewise writable, mic reset
// - format via four bit verbs, pcm only
// - bit 14 selects 48k or 44.1k
// - multiplier decode x1, x2, x4
// - divisor is field plus one
// - sample width code, reset 24 bits
// - channel count field plus one, reset two
// - right amp mute and gain, reset muted
// - left amp same layout, own storage
// - converter answers at node 0x10
// - converter caps word fixed values
// - jack node answers at node 0x0f
// - jack node caps advertise event reports
// - power codes 11 down, others on
`timescale 1ns/1ns
module jpdn_nodes
  import jpdn_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                link_clk,
  input  wire logic                verb_valid,
  input  wire logic [7:0]          verb_node,
  input  wire logic [19:0]         verb_code,
  output logic                     resp_valid,
  output logic [31:0]              resp_data,
  output logic                     unsol_valid,
  output logic [31:0]              unsol_data,
  input  wire logic                jack_detect_pin,
  input  wire logic                dac_enable_pin,
  output logic                     meas_start,
  output logic                     meas_ring_side,
  input  wire logic                meas_done,
  input  wire logic [30:0]         meas_value,
  output logic                     output_path_enable,
  output logic                     input_path_enable,
  output logic [2:0]               bias_level_select,
  output logic [15:0]              stream_format,
  output logic [RATE_W-1:0]        sample_rate_hz,
  output logic [7:0]               right_gain_mute,
  output logic [7:0]               left_gain_mute,
  output logic                     dac_powered_up
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [2:0] bias_fix(input logic [2:0] code);
    bias_fix = BIAS_SUPPORT[code] ? code : 3'h0;
  endfunction : bias_fix

  function automatic logic [RATE_W-1:0] rate_of(input logic [15:0] fmt);
    int base;
    int mult;
    base = fmt[14] ? RATE_44K1_HZ : RATE_48K_HZ;
    case (fmt[13:11])
      3'h1:    mult = 2;
      3'h3:    mult = 4;
      default: mult = 1;
    endcase
    rate_of = RATE_W'((base * mult) / (int'(fmt[10:8]) + 1));
  endfunction : rate_of

  ////////////////////////////////////////////////////////////////////////////
  // link domain reset and pin synchronisers

  logic       lrst_s1_q;
  logic       lrst_q;
  logic       jack_s1_q;
  logic       jack_s2_q;
  logic       jack_d_q;
  logic       dac_s1_q;
  logic       dac_on_q;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_q <= srst;
    lrst_q    <= lrst_s1_q;
    jack_s1_q <= jack_detect_pin;
    jack_s2_q <= jack_s1_q;
    dac_s1_q  <= dac_enable_pin;
    dac_on_q  <= dac_s1_q;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      jack_d_q <= 1'b0;
    else
      jack_d_q <= jack_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verb decode

  logic        to_jack;
  logic        to_dac;
  logic [11:0] vrb;
  logic [7:0]  pay;
  logic        set_fmt;

  assign to_jack = verb_valid && (verb_node == NODE_JACK);
  assign to_dac  = verb_valid && (verb_node == NODE_DAC);
  assign vrb     = verb_code[19:8];
  assign pay     = verb_code[7:0];
  assign set_fmt = to_dac && (verb_code[19:16] == VRB4_SET_FORMAT);

  ////////////////////////////////////////////////////////////////////////////
  // jack node state

  logic [7:0]  pin_ctl_q;
  logic [7:0]  evt_ctl_q;
  logic [31:0] config_q;
  logic        sense_side_q;
  logic        trig_tgl_q;
  logic [30:0] imp_q;
  logic        done_s1_q;
  logic        done_s2_q;
  logic        done_d_q;
  logic        done_edge;
  logic        done_tgl_q;
  logic [30:0] result_q;

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      pin_ctl_q <= 8'h00;
    else if (to_jack && vrb == VRB_SET_PIN_CTL)
      pin_ctl_q <= {1'b0, pay[CTL_OUT_BIT], pay[CTL_IN_BIT], 2'b00, bias_fix(pay[2:0])};
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      evt_ctl_q <= 8'h00;
    else if (to_jack && vrb == VRB_SET_EVT_CTL)
      evt_ctl_q <= {pay[7], 1'b0, pay[5:0]};
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      config_q <= CONFIG_RST;
    else if (to_jack)
    begin
      case (vrb)
        VRB_SET_CONFIG0: config_q[7:0]   <= pay;
        VRB_SET_CONFIG1: config_q[15:8]  <= pay;
        VRB_SET_CONFIG2: config_q[23:16] <= pay;
        VRB_SET_CONFIG3: config_q[31:24] <= pay;
        default:         config_q        <= config_q;
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      sense_side_q <= 1'b0;
      trig_tgl_q   <= 1'b0;
    end
    else if (to_jack && vrb == VRB_SET_SENSE)
    begin
      sense_side_q <= pay[0];
      trig_tgl_q   <= ~trig_tgl_q;
    end
  end

  // result toggle back from the measurement side
  always_ff @(posedge link_clk)
  begin
    done_s1_q <= done_tgl_q;
    done_s2_q <= done_s1_q;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      done_d_q <= 1'b0;
    else
      done_d_q <= done_s2_q;
  end

  assign done_edge = done_s2_q ^ done_d_q;

  // all ones while busy or unknown
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      imp_q <= IMP_UNKNOWN;
    else if (to_jack && vrb == VRB_SET_SENSE)
      imp_q <= IMP_UNKNOWN;
    else if (done_edge)
      imp_q <= result_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter node state

  logic [15:0] fmt_q;
  logic [7:0]  amp_r_q;
  logic [7:0]  amp_l_q;
  logic [1:0]  power_q;

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      fmt_q <= FORMAT_RST;
    else if (set_fmt)
      // stream kind and bit 7 forced zero
      fmt_q <= verb_code[15:0] & FORMAT_RW_MASK;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      amp_r_q <= AMP_RST;
    else if (to_dac && vrb == VRB_SET_AMP_R)
      amp_r_q <= pay;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      amp_l_q <= AMP_RST;
    else if (to_dac && vrb == VRB_SET_AMP_L)
      amp_l_q <= pay;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
      power_q <= POWER_RST;
    else if (to_dac && vrb == VRB_SET_POWER)
      power_q <= pay[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // responses

  logic [31:0] get_word;

  always_comb
  begin
    get_word = 32'h0000_0000;
    if (to_jack)
    begin
      case (vrb)
        VRB_GET_PARAM:
        begin
          if (pay == PAR_PIN_CAPS)
            get_word = PIN_CAPS_BASE | (32'(dac_on_q) << PC_OUT_BIT);
          else if (pay == PAR_LIST_LEN)
            get_word = {31'h0, dac_on_q};
          else if (pay == PAR_NODE_CAPS)
            get_word = PIN_NODE_CAPS | (32'(dac_on_q) << WC_LIST_BIT);
        end
        VRB_GET_SRC_LIST: get_word = dac_on_q ? {25'h0, NODE_SOURCE} : 32'h0;
        VRB_GET_PIN_CTL:  get_word = {24'h0, pin_ctl_q};
        VRB_GET_EVT_CTL:  get_word = {24'h0, evt_ctl_q};
        VRB_GET_SENSE:    get_word = {jack_s2_q, imp_q};
        VRB_GET_CONFIG:   get_word = config_q;
        default:          get_word = 32'h0000_0000;
      endcase
    end
    else if (to_dac)
    begin
      if (verb_code[19:16] == VRB4_GET_FORMAT)
        get_word = {16'h0, fmt_q};
      else
      begin
        case (vrb)
          VRB_GET_PARAM:  get_word = (pay == PAR_NODE_CAPS) ? DAC_NODE_CAPS : 32'h0;
          VRB_GET_AMP_R:  get_word = {24'h0, amp_r_q};
          VRB_GET_AMP_L:  get_word = {24'h0, amp_l_q};
          VRB_GET_POWER:  get_word = {24'h0, 2'b00, power_q, 2'b00, power_q};
          default:        get_word = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      resp_valid <= 1'b0;
      resp_data  <= 32'h0;
    end
    else
    begin
      resp_valid <= to_jack || to_dac;
      resp_data  <= get_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unsolicited responses

  logic insert_evt;

  assign insert_evt = jack_s2_q && !jack_d_q;

  // gated by enable, tagged on top
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      unsol_valid <= 1'b0;
      unsol_data  <= 32'h0;
    end
    else
    begin
      unsol_valid <= evt_ctl_q[EVT_EN_BIT] && (insert_evt || done_edge);
      unsol_data  <= {evt_ctl_q[5:0], 26'h0} << (TAG_LSB - 26);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register driven outputs

  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      output_path_enable <= 1'b0;
      input_path_enable  <= 1'b0;
      bias_level_select  <= 3'h0;
      stream_format      <= FORMAT_RST;
      sample_rate_hz     <= rate_of(FORMAT_RST);
      right_gain_mute    <= AMP_RST;
      left_gain_mute     <= AMP_RST;
      dac_powered_up     <= 1'b0;
    end
    else
    begin
      output_path_enable <= pin_ctl_q[CTL_OUT_BIT];
      input_path_enable  <= pin_ctl_q[CTL_IN_BIT];
      bias_level_select  <= pin_ctl_q[2:0];
      stream_format      <= fmt_q;
      sample_rate_hz     <= rate_of(fmt_q);
      right_gain_mute    <= amp_r_q;
      left_gain_mute     <= amp_l_q;
      dac_powered_up     <= (power_q != POWER_DOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement side on clock

  logic        trig_s1_q;
  logic        trig_s2_q;
  logic        trig_d_q;
  logic        busy_q;

  always_ff @(posedge clock)
  begin
    trig_s1_q <= trig_tgl_q;
    trig_s2_q <= trig_s1_q;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      trig_d_q       <= 1'b0;
      meas_start     <= 1'b0;
      meas_ring_side <= 1'b0;
      busy_q         <= 1'b0;
    end
    else
    begin
      trig_d_q   <= trig_s2_q;
      meas_start <= trig_s2_q ^ trig_d_q;
      if (trig_s2_q ^ trig_d_q)
      begin
        meas_ring_side <= sense_side_q;
        busy_q         <= 1'b1;
      end
      else if (meas_done)
        busy_q <= 1'b0;
    end
  end

  // result held stable while its toggle crosses
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      done_tgl_q <= 1'b0;
      result_q   <= IMP_UNKNOWN;
    end
    else if (busy_q && meas_done && !meas_start)
    begin
      done_tgl_q <= ~done_tgl_q;
      result_q   <= meas_value;
    end
  end

endmodule : jpdn_nodes

// ===== sim/jpdn_nodes_sva.sv
// concurrent checks on the jack and converter node ports
// assumes a bind onto jpdn_nodes; verbs on link_clk, measurement on clock
`timescale 1ns/1ns
module jpdn_nodes_sva
  import jpdn_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        link_clk,
  input wire logic        verb_valid,
  input wire logic [7:0]  verb_node,
  input wire logic [19:0] verb_code,
  input wire logic        resp_valid,
  input wire logic [31:0] resp_data,
  input wire logic        unsol_valid,
  input wire logic [31:0] unsol_data,
  input wire logic        meas_start,
  input wire logic        meas_ring_side,
  input wire logic        output_path_enable,
  input wire logic        input_path_enable,
  input wire logic [2:0]  bias_level_select,
  input wire logic [15:0] stream_format,
  input wire logic [7:0]  right_gain_mute
);
  logic       hit;
  logic [5:0] tag_q;
  assign hit = verb_valid && (verb_node == 8'h0f || verb_node == 8'h10);
  // remembers the event tag last written
  always_ff @(posedge link_clk)
  begin
    if (srst)
      tag_q <= 6'h00;
    else if (hit && verb_node == 8'h0f && verb_code[19:8] == 12'h708)
      tag_q <= verb_code[5:0];
  end
  sequence s_set(logic [7:0] n, logic [11:0] v);
    hit && verb_node == n && verb_code[19:8] == v;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  node_answer_a: assert property (@(posedge link_clk) disable iff (srst)
    hit |=> resp_valid) else $error("accepted verb not answered");
  foreign_node_a: assert property (@(posedge link_clk) disable iff (srst)
    verb_valid && !hit |=> !resp_valid) else $error("foreign node answered");
  set_zero_a: assert property (@(posedge link_clk) disable iff (srst)
    hit && verb_code[19:16] inside {4'h7, 4'h3, 4'h2} |=> resp_data == 32'h0)
    else $error("set verb answer not zero");
  event_tag_a: assert property (@(posedge link_clk) disable iff (srst)
    unsol_valid |-> unsol_data == {tag_q, 26'h0}) else $error("event word wrong");
  bias_legal_a: assert property (@(posedge link_clk) disable iff (srst)
    bias_level_select inside {3'h0, 3'h1, 3'h2, 3'h4}) else $error("bias code illegal");
  pin_ctl_a: assert property (@(posedge link_clk) disable iff (srst)
    s_set(8'h0f, 12'h707) |-> ##2 (output_path_enable == $past(verb_code[6], 2)
    && input_path_enable == $past(verb_code[5], 2))) else $error("path enables wrong");
  right_amp_a: assert property (@(posedge link_clk) disable iff (srst)
    s_set(8'h10, 12'h390) |-> ##2 right_gain_mute == $past(verb_code[7:0], 2))
    else $error("right amp not stored");
  pcm_only_a: assert property (@(posedge link_clk) disable iff (srst)
    stream_format[15] == 1'b0) else $error("stream kind not pcm");
  meas_pulse_a: assert property (@(posedge clock) disable iff (srst)
    meas_start |=> !meas_start && $stable(meas_ring_side)) else $error("trigger not a pulse");
endmodule : jpdn_nodes_sva

// ===== sim/jpdn_host_model.sv
// link host: issues one verb at a time and collects the answer
// assumes verbs are taken on rising link_clk, answer one cycle later
`timescale 1ns/1ns
module jpdn_host_model
  import jpdn_pkg::*;
(
  input  wire logic        link_clk,
  output logic             verb_valid,
  output logic [7:0]       verb_node,
  output logic [19:0]      verb_code,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_data
);
  initial
  begin
    verb_valid = 1'b0;
    verb_node  = 8'h00;
    verb_code  = 20'h0;
  end
  // released lines show the inverse, not the last value
  task automatic xfer(input logic [7:0] n, input logic [19:0] c, output logic g,
                      output logic [31:0] d);
    @(posedge link_clk);
    #1;
    verb_valid = 1'b1;
    verb_node  = n;
    verb_code  = c;
    @(posedge link_clk);
    #1;
    g = resp_valid;
    d = resp_data;
    verb_valid = 1'b0;
    verb_node  = ~n;
    verb_code  = ~c;
  endtask : xfer
endmodule : jpdn_host_model

// ===== sim/test_jack_pin_and_dac_verb_nodes.sv
// self-checking bench for the jack and converter node block
// assumes jpdn_pkg, host model and checker are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module test_jack_pin_and_dac_verb_nodes
  import jpdn_pkg::*;
;
  logic              clock, srst, link_clk, verb_valid, resp_valid, unsol_valid, meas_done;
  logic              jack_detect_pin, dac_enable_pin, meas_start, meas_ring_side;
  logic              output_path_enable, input_path_enable, dac_powered_up;
  logic [7:0]        verb_node, right_gain_mute, left_gain_mute;
  logic [19:0]       verb_code;
  logic [31:0]       resp_data, unsol_data, r;
  logic [30:0]       meas_value;
  logic [2:0]        bias_level_select;
  logic [15:0]       stream_format;
  logic [RATE_W-1:0] sample_rate_hz;
  int                err_total, compares;
  jpdn_nodes dut_u (.clock(clock), .srst(srst), .link_clk(link_clk), .verb_valid(verb_valid),
    .verb_node(verb_node), .verb_code(verb_code), .resp_valid(resp_valid),
    .resp_data(resp_data), .unsol_valid(unsol_valid), .unsol_data(unsol_data),
    .jack_detect_pin(jack_detect_pin), .dac_enable_pin(dac_enable_pin),
    .meas_start(meas_start), .meas_ring_side(meas_ring_side), .meas_done(meas_done),
    .meas_value(meas_value), .output_path_enable(output_path_enable),
    .input_path_enable(input_path_enable), .bias_level_select(bias_level_select),
    .stream_format(stream_format), .sample_rate_hz(sample_rate_hz),
    .right_gain_mute(right_gain_mute), .left_gain_mute(left_gain_mute),
    .dac_powered_up(dac_powered_up));
  jpdn_host_model host_u (.link_clk(link_clk), .verb_valid(verb_valid),
    .verb_node(verb_node), .verb_code(verb_code), .resp_valid(resp_valid),
    .resp_data(resp_data));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end
  // measurement front end: answers four cycles after a trigger
  initial
  begin
    meas_done = 1'b0;
    meas_value = 31'h0;
    forever
    begin
      @(posedge clock);
      #1;
      meas_done = 1'b0;
      meas_value = ~meas_value;
      if (meas_start)
      begin
        repeat (4) @(posedge clock);
        #1;
        meas_done = 1'b1;
        meas_value = meas_ring_side ? 31'h1234 : 31'h0567;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic vget(input logic [7:0] n, input logic [19:0] c, input logic [31:0] w);
    logic g;
    host_u.xfer(n, c, g, r);
    `CHK(g, 1'b1)
    `CHK(r, w)
  endtask : vget
  task automatic vset(input logic [7:0] n, input logic [19:0] c);
    vget(n, c, 32'h0);
  endtask : vset
  task automatic wait_unsol(input logic [31:0] w);
    int n;
    n = 0;
    while (unsol_valid !== 1'b1 && n < 200)
    begin
      @(posedge link_clk);
      #1;
      n++;
    end
    `CHK(unsol_valid, 1'b1)
    `CHK(unsol_data, w)
    @(posedge link_clk);
  endtask : wait_unsol
  task automatic t_reset;
    `CHK(stream_format, 16'h0031)
    `CHK(sample_rate_hz, RATE_W'(48000))
    `CHK({right_gain_mute, left_gain_mute}, 16'hffff)
    `CHK({dac_powered_up, output_path_enable, input_path_enable}, 3'h0)
    vget(8'h0f, 20'hf1c00, 32'h01a1_9040);
    vget(8'h0f, 20'hf0900, 32'h7fff_ffff);
  endtask : t_reset
  task automatic t_caps;
    logic g;
    for (int e = 0; e < 2; e++)
    begin
      @(posedge clock);
      #1 dac_enable_pin = e[0];
      repeat (6) @(posedge link_clk);
      vget(8'h0f, 20'hf000c, 32'h0000_1727 | {27'h0, e[0], 4'h0});
      vget(8'h0f, 20'hf000e, {31'h0, e[0]});
      vget(8'h0f, 20'hf0009, 32'h0040_0081 | {23'h0, e[0], 8'h0});
      vget(8'h0f, 20'hf0200, e[0] ? 32'h11 : 32'h0);
    end
    vget(8'h10, 20'hf0009, 32'h000d_0c05);
    host_u.xfer(8'h12, 20'hf0009, g, r);
    `CHK(g, 1'b0)
  endtask : t_caps
  task automatic t_jack_port_control;
    logic [2:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = (i == 3 || i > 4) ? 3'h0 : i[2:0];
      vset(8'h0f, {12'h707, 1'b1, i[0], ~i[0], 2'b11, i[2:0]});
      vget(8'h0f, 20'hf0700, {25'h0, i[0], ~i[0], 2'b00, b});
      `CHK(bias_level_select, b)
      `CHK({output_path_enable, input_path_enable}, {i[0], ~i[0]})
    end
  endtask : t_jack_port_control
  task automatic t_config;
    vset(8'h0f, 20'h71c1f);
    vset(8'h0f, 20'h71d29);
    vset(8'h0f, 20'h71e32);
    vset(8'h0f, 20'h71f41);
    vget(8'h0f, 20'hf1c00, 32'h4132_291f);
  endtask : t_config
  task automatic t_format;
    logic [15:0] f [6] = '{16'h4000, 16'h0811, 16'h1b00, 16'hd9f2, 16'h0700, 16'h1000};
    int          hz [6] = '{44100, 96000, 48000, 88200, 6000, 48000};
    for (int i = 0; i < 6; i++)
    begin
      vset(8'h10, {4'h2, f[i]});
      vget(8'h10, 20'ha0000, {16'h0, f[i] & 16'h7f7f});
      `CHK(stream_format, f[i] & 16'h7f7f)
      `CHK(sample_rate_hz, RATE_W'(hz[i]))
    end
  endtask : t_format
  task automatic t_amp_power;
    vset(8'h10, 20'h39025);
    vset(8'h10, 20'h3a09a);
    vget(8'h10, 20'hb8000, 32'h25);
    vget(8'h10, 20'hba000, 32'h9a);
    `CHK({right_gain_mute, left_gain_mute}, 16'h259a)
    for (int i = 0; i < 4; i++)
    begin
      vset(8'h10, {12'h705, 6'h0, i[1:0]});
      vget(8'h10, 20'hf0500, {26'h0, i[1:0], 2'b00, i[1:0]});
      `CHK(dac_powered_up, i != 3)
    end
  endtask : t_amp_power
  task automatic t_sense;
    vset(8'h0f, 20'h708aa);
    vget(8'h0f, 20'hf0800, 32'haa);
    @(posedge clock);
    #1 jack_detect_pin = 1'b1;
    wait_unsol(32'ha800_0000);
    for (int s = 1; s >= 0; s--)
    begin
      vset(8'h0f, {12'h709, 7'h0, s[0]});
      vget(8'h0f, 20'hf0900, 32'hffff_ffff);
      wait_unsol(32'ha800_0000);
      `CHK(meas_ring_side, s[0])
      vget(8'h0f, 20'hf0900, {1'b1, s[0] ? 31'h1234 : 31'h0567});
    end
  endtask : t_sense
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    err_total = 0;
    compares = 0;
    srst = 1'b1;
    jack_detect_pin = 1'b0;
    dac_enable_pin = 1'b1;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    repeat (4) @(posedge link_clk);
    t_reset;
    t_caps;
    t_jack_port_control;
    t_config;
    t_format;
    t_amp_power;
    t_sense;
    print_verdict;
  end
  initial
  begin
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict;
  end
endmodule : test_jack_pin_and_dac_verb_nodes
bind jpdn_nodes jpdn_nodes_sva chk_u (.clock(clock), .srst(srst), .link_clk(link_clk),
  .verb_valid(verb_valid), .verb_node(verb_node), .verb_code(verb_code),
  .resp_valid(resp_valid), .resp_data(resp_data), .unsol_valid(unsol_valid),
  .unsol_data(unsol_data), .meas_start(meas_start), .meas_ring_side(meas_ring_side),
  .output_path_enable(output_path_enable), .input_path_enable(input_path_enable),
  .bias_level_select(bias_level_select), .stream_format(stream_format),
  .right_gain_mute(right_gain_mute));
